// ---- inc/dafc_defines.vh ----
`ifndef DAFC_DEFINES_VH
`define DAFC_DEFINES_VH
// Array sizes in bytes for the two variants.
`define DAFC_LARGE_A_BYTES   16384
`define DAFC_SMALL_A_BYTES   2048
`define DAFC_B_BYTES         16384
// Page size in bytes and lowest page address bit.
`define DAFC_PAGE_BYTES      512
`define DAFC_PAGE_LSB        9
// Operation lengths in flash timing clock cycles.
`define DAFC_T_BYTE_PROG     15'h0009
`define DAFC_T_BURST_PROG    15'h0004
`define DAFC_T_PAGE_ERASE    15'h0FA0
`define DAFC_T_MASS_ERASE    15'h4E20
// Command codes.
`define DAFC_CMD_BLANK       3'h0
`define DAFC_CMD_PROG        3'h1
`define DAFC_CMD_BURST       3'h2
`define DAFC_CMD_PAGE_ERASE  3'h3
`define DAFC_CMD_MASS_ERASE  3'h4
// Divider field layout and reset value.
`define DAFC_DIV_PRESCALE    6
`define DAFC_DIV_RESET       7'h00
// Bus cycles without a read before the arrays power down.
`define DAFC_IDLE_CYCLES     5'h10
`endif

// ---- rtl/dafc_tick_gen.v ----
`timescale 1ns/10ps
`default_nettype none
`include "dafc_defines.vh"
// Flash timing tick: bus clock, optional divide by 8, then divide by value plus one.
module dafc_tick_gen
(
   input  wire       core_clk,
   input  wire       arst_n,
   input  wire       run,
   input  wire [6:0] divider,
   output reg        tick
);
   reg [2:0] pre;
   reg [5:0] cnt;
   wire      pre_tick;

   // Prescaler passes every bus cycle or every eighth one.
   assign pre_tick = divider[`DAFC_DIV_PRESCALE] ? (pre == 3'h7) : 1'b1;

   // Counters run only while enabled so each operation starts aligned.
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pre  <= 3'h0;
         cnt  <= 6'h00;
         tick <= 1'b0;
      end
      else if (!run)
      begin
         pre  <= 3'h0;
         cnt  <= 6'h00;
         tick <= 1'b0;
      end
      else
      begin
         pre  <= pre + 3'h1;
         tick <= 1'b0;
         if (pre_tick)
         begin
            if (cnt == divider[5:0])
            begin
               cnt  <= 6'h00;
               tick <= 1'b1;
            end
            else
               cnt <= cnt + 6'h01;
         end
      end
   end
endmodule
`default_nettype wire

// ---- rtl/dafc_flash_ctrl.v ----
// Functional notes
// - Reads from idle array never stall.
// - One command port; address selects array.
// - Never two program/erase operations at once.
// - Mass erase clears both arrays.
// - Blank check covers both arrays, one result.
// - One protection boundary, one security state.
// - Array sizes per variant.
// - Hardware times program and erase pulses.
// - Arrays power down between slow reads.
// - Divider written once; commands need loaded flag.
// - Operation lengths in timing clock cycles.
// - Page erase covers one 512-byte page.
// - Error and done status flags.
`timescale 1ns/10ps
`default_nettype none
`include "dafc_defines.vh"
module dafc_flash_ctrl
#(
   parameter SMALL_VARIANT = 0,
   parameter ADDR_W        = 15
)
(
   input  wire              core_clk,
   input  wire              arst_n,
   input  wire              div_wr,
   input  wire [6:0]        div_wdata,
   output wire [7:0]        flash_clock_divider,
   output wire              divider_loaded_flag,
   input  wire              cmd_launch,
   input  wire [2:0]        cmd_code,
   input  wire [ADDR_W-1:0] cmd_addr,
   input  wire              err_clear,
   input  wire              done_clear,
   output reg               access_error_flag,
   output reg               protect_error_flag,
   output reg               cmd_done,
   output reg               busy,
   output reg               blank_fail,
   input  wire [ADDR_W-1:0] prot_boundary,
   input  wire              secure,
   input  wire              rd_req,
   input  wire [ADDR_W-1:0] rd_addr,
   output reg               rd_valid,
   output reg               rd_invalid,
   output reg               pump_on,
   output reg [1:0]         erase_en,
   output reg [1:0]         prog_en,
   output reg [ADDR_W-1:0]  op_addr,
   output reg [1:0]         array_pwr,
   input  wire [1:0]        array_blank
);
   // =====================================================================
   // Constants and array decode
   // =====================================================================
   localparam ST_IDLE = 2'h0;
   localparam ST_RUN  = 2'h1;
   localparam ST_DONE = 2'h2;
   localparam [ADDR_W-1:0] A_BYTES = SMALL_VARIANT ? `DAFC_SMALL_A_BYTES
                                                   : `DAFC_LARGE_A_BYTES;
   localparam [ADDR_W:0] TOTAL = A_BYTES + `DAFC_B_BYTES;

   // Selects array B when the address lies above array A.
   function sel_b;
      input [ADDR_W-1:0] a;
      begin
         sel_b = (a >= A_BYTES);
      end
   endfunction

   // Address inside the joined memory.
   function in_range;
      input [ADDR_W-1:0] a;
      begin
         in_range = ({1'b0, a} < TOTAL);
      end
   endfunction

   reg [6:0]  div_val;
   reg        div_loaded;
   reg [1:0]  state;
   reg [2:0]  op_code;
   reg        op_b;
   reg [14:0] tick_cnt;
   reg [14:0] op_len;
   reg [4:0]  idle_cnt;
   wire       tick;
   wire       launch_ok;
   wire       prot_hit;

   assign flash_clock_divider = {div_loaded, div_val};
   assign divider_loaded_flag = div_loaded;

   // =====================================================================
   // Divider register
   // =====================================================================
   // First write loads value and flag; later writes, or writes while an
   // access error stands, are ignored.
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         div_val    <= `DAFC_DIV_RESET;
         div_loaded <= 1'b0;
      end
      else if (div_wr && !div_loaded && !access_error_flag)
      begin
         div_val    <= div_wdata;
         div_loaded <= 1'b1;
      end
   end

   // =====================================================================
   // Command acceptance
   // =====================================================================
   // Protection and security see both arrays as one address space.
   assign prot_hit  = secure || (cmd_addr >= prot_boundary) ||
                      !in_range(cmd_addr);
   assign launch_ok = cmd_launch && div_loaded && (state == ST_IDLE) &&
                      (cmd_code == `DAFC_CMD_BLANK || cmd_code == `DAFC_CMD_MASS_ERASE ||
                       !prot_hit);

   // Length of the accepted operation in timing ticks.
   always @*
   begin
      case (cmd_code)
         `DAFC_CMD_PROG:       op_len = `DAFC_T_BYTE_PROG;
         `DAFC_CMD_BURST:      op_len = `DAFC_T_BURST_PROG;
         `DAFC_CMD_PAGE_ERASE: op_len = `DAFC_T_PAGE_ERASE;
         `DAFC_CMD_MASS_ERASE: op_len = `DAFC_T_MASS_ERASE;
         default:              op_len = 15'h0001;
      endcase
   end

   dafc_tick_gen u_tick
   (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .run      (state == ST_RUN),
      .divider  (div_val),
      .tick     (tick)
   );

   // =====================================================================
   // Sequencer
   // =====================================================================
   // One operation at a time; pulses are counted in hardware ticks.
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state    <= ST_IDLE;
         op_code  <= `DAFC_CMD_BLANK;
         op_b     <= 1'b0;
         op_addr  <= {ADDR_W{1'b0}};
         tick_cnt <= 15'h0000;
         busy     <= 1'b0;
         pump_on  <= 1'b0;
         erase_en <= 2'b00;
         prog_en  <= 2'b00;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               if (launch_ok)
               begin
                  state    <= ST_RUN;
                  busy     <= 1'b1;
                  op_code  <= cmd_code;
                  op_b     <= sel_b(cmd_addr);
                  tick_cnt <= op_len;
                  pump_on  <= (cmd_code != `DAFC_CMD_BLANK);
                  if (cmd_code == `DAFC_CMD_PAGE_ERASE)
                     op_addr <= {cmd_addr[ADDR_W-1:`DAFC_PAGE_LSB],
                                 {`DAFC_PAGE_LSB{1'b0}}};
                  else
                     op_addr <= cmd_addr;
                  case (cmd_code)
                     `DAFC_CMD_MASS_ERASE: erase_en <= 2'b11;
                     `DAFC_CMD_PAGE_ERASE:
                        erase_en <= sel_b(cmd_addr) ? 2'b10 : 2'b01;
                     `DAFC_CMD_PROG, `DAFC_CMD_BURST:
                        prog_en <= sel_b(cmd_addr) ? 2'b10 : 2'b01;
                     default: erase_en <= 2'b00;
                  endcase
               end
            end
            ST_RUN:
            begin
               if (tick)
               begin
                  if (tick_cnt == 15'h0001)
                  begin
                     state    <= ST_DONE;
                     pump_on  <= 1'b0;
                     erase_en <= 2'b00;
                     prog_en  <= 2'b00;
                  end
                  else
                     tick_cnt <= tick_cnt - 15'h0001;
               end
            end
            ST_DONE:
            begin
               state <= ST_IDLE;
               busy  <= 1'b0;
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // =====================================================================
   // Status flags
   // =====================================================================
   // Hardware sets win over software clears.
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         access_error_flag  <= 1'b0;
         protect_error_flag <= 1'b0;
         cmd_done           <= 1'b0;
         blank_fail         <= 1'b0;
      end
      else
      begin
         if (cmd_launch && (!div_loaded || state != ST_IDLE))
            access_error_flag <= 1'b1;
         else if (err_clear)
            access_error_flag <= 1'b0;
         if (cmd_launch && div_loaded && state == ST_IDLE && !launch_ok)
            protect_error_flag <= 1'b1;
         else if (err_clear)
            protect_error_flag <= 1'b0;
         if (state == ST_DONE)
            cmd_done <= 1'b1;
         else if (done_clear || launch_ok)
            cmd_done <= 1'b0;
         if (state == ST_DONE && op_code == `DAFC_CMD_BLANK)
            blank_fail <= !(&array_blank);
      end
   end

   // =====================================================================
   // Read path and auto power-down
   // =====================================================================
   // Reads to the idle array pass; reads to the busy one are flagged.
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rd_valid   <= 1'b0;
         rd_invalid <= 1'b0;
         idle_cnt   <= 5'h00;
         array_pwr  <= 2'b00;
      end
      else
      begin
         rd_valid   <= 1'b0;
         rd_invalid <= 1'b0;
         if (rd_req)
         begin
            idle_cnt <= 5'h00;
            array_pwr <= 2'b11;
            if (busy && (op_code == `DAFC_CMD_MASS_ERASE ||
                         (op_code != `DAFC_CMD_BLANK && sel_b(rd_addr) == op_b)))
               rd_invalid <= 1'b1;
            else
               rd_valid <= 1'b1;
         end
         else if (idle_cnt == `DAFC_IDLE_CYCLES)
            array_pwr <= 2'b00;
         else
            idle_cnt <= idle_cnt + 5'h01;
      end
   end
endmodule
`default_nettype wire

// ---- testbench/dafc_flash_ctrl_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module dafc_flash_ctrl_asserts
(
   input wire logic       core_clk,
   input wire logic       arst_n,
   input wire logic       cmd_launch,
   input wire logic [2:0] cmd_code,
   input wire logic       busy,
   input wire logic       cmd_done,
   input wire logic       access_error_flag,
   input wire logic       divider_loaded_flag,
   input wire logic [7:0] flash_clock_divider,
   input wire logic [1:0] prog_en,
   input wire logic [1:0] erase_en,
   input wire logic       rd_req,
   input wire logic       rd_valid,
   input wire logic       rd_invalid,
   input wire logic [1:0] array_pwr
);
   default clocking dcb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   logic [5:0] idle_cnt;
   // Counts bus cycles with no read and no operation.
   always @(posedge core_clk or negedge arst_n)
      if (!arst_n)
         idle_cnt <= 6'h00;
      else if (rd_req || busy)
         idle_cnt <= 6'h00;
      else if (idle_cnt != 6'h3F)
         idle_cnt <= idle_cnt + 6'h01;
   sequence s_free_launch;
      cmd_launch && divider_loaded_flag && !busy && (cmd_code == 3'h0 || cmd_code == 3'h4);
   endsequence
   sequence s_read_answer;
      rd_valid && !rd_invalid;
   endsequence
   a_launch_takes_busy: assert property (s_free_launch |=> busy)
      else $error("accepted launch did not raise busy");
   a_busy_launch_err: assert property (cmd_launch && busy |=> access_error_flag)
      else $error("launch while busy not refused");
   a_unloaded_refused: assert property (cmd_launch && !divider_loaded_flag |=> access_error_flag && !busy)
      else $error("launch before divider load not refused");
   a_divider_frozen: assert property (divider_loaded_flag |=> $stable(flash_clock_divider))
      else $error("divider changed after load");
   a_flag_mirror: assert property (flash_clock_divider[7] == divider_loaded_flag)
      else $error("loaded bit differs from flag");
   a_one_operation: assert property (prog_en != 2'b11 && !(|prog_en && |erase_en))
      else $error("two operations at once");
   a_idle_read_ok: assert property (rd_req && !busy |=> s_read_answer)
      else $error("idle read not answered");
   a_no_spurious_read: assert property (!rd_req |=> !rd_valid && !rd_invalid)
      else $error("read answer without request");
   a_done_ends_busy: assert property ($rose(cmd_done) |-> ##[0:1] !busy)
      else $error("busy stands after done");
   a_power_down: assert property (idle_cnt == 6'd20 |-> array_pwr == 2'b00)
      else $error("arrays stay powered while idle");
endmodule
bind dafc_flash_ctrl dafc_flash_ctrl_asserts dafc_flash_ctrl_asserts_i (.core_clk(core_clk),
   .arst_n(arst_n), .cmd_launch(cmd_launch), .cmd_code(cmd_code), .busy(busy),
   .cmd_done(cmd_done), .access_error_flag(access_error_flag),
   .divider_loaded_flag(divider_loaded_flag), .flash_clock_divider(flash_clock_divider),
   .prog_en(prog_en), .erase_en(erase_en), .rd_req(rd_req), .rd_valid(rd_valid),
   .rd_invalid(rd_invalid), .array_pwr(array_pwr));
`default_nettype wire

// ---- testbench/dafc_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module dafc_host_model
(
   input wire logic         core_clk,
   input wire logic         arst_n,
   input wire logic         fetch_en,
   input wire logic         fetch_arr,
   output var logic         rd_req,
   output var logic [14:0]  rd_addr
);
   // Fetches from the chosen array; interrupts are taken as masked, so no vector fetch.
   // Between fetches the address is inverted so no stale value looks valid.
   always @(posedge core_clk or negedge arst_n)
      if (!arst_n)
      begin
         rd_req <= 1'b0;
         rd_addr <= 15'h0000;
      end
      else
      begin
         rd_req <= fetch_en;
         rd_addr <= fetch_en ? {fetch_arr, 14'($urandom)} : ~rd_addr;
      end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic core_clk, arst_n, div_wr, cmd_launch, err_clear, done_clear, secure, fetch_en, fetch_arr;
   logic divider_loaded_flag, access_error_flag, protect_error_flag, cmd_done, busy;
   logic blank_fail, rd_req, rd_valid, rd_invalid, pump_on;
   logic [6:0]  div_wdata;
   logic [2:0]  cmd_code;
   logic [14:0] cmd_addr, prot_boundary, rd_addr, op_addr, a;
   logic [1:0]  array_blank, erase_en, prog_en, array_pwr, en;
   logic [7:0]  flash_clock_divider;
   int          n_mismatch, comparisons, n, len;
   dafc_flash_ctrl #(.SMALL_VARIANT(0), .ADDR_W(15)) dafc_flash_ctrl_i (.core_clk(core_clk),
      .arst_n(arst_n), .div_wr(div_wr), .div_wdata(div_wdata),
      .flash_clock_divider(flash_clock_divider), .divider_loaded_flag(divider_loaded_flag),
      .cmd_launch(cmd_launch), .cmd_code(cmd_code), .cmd_addr(cmd_addr), .err_clear(err_clear),
      .done_clear(done_clear), .access_error_flag(access_error_flag),
      .protect_error_flag(protect_error_flag), .cmd_done(cmd_done), .busy(busy),
      .blank_fail(blank_fail), .prot_boundary(prot_boundary), .secure(secure),
      .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_invalid(rd_invalid),
      .pump_on(pump_on), .erase_en(erase_en), .prog_en(prog_en), .op_addr(op_addr),
      .array_pwr(array_pwr), .array_blank(array_blank));
   dafc_host_model dafc_host_model_i (.core_clk(core_clk), .arst_n(arst_n),
      .fetch_en(fetch_en), .fetch_arr(fetch_arr), .rd_req(rd_req), .rd_addr(rd_addr));
   // ==========================================
   // Clock and shared tasks.
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task automatic chk(input logic ok, input string m);
      comparisons++;
      if (ok !== 1'b1)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t %s", $time, m);
      end
   endtask
   task automatic close_out;
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Ticks per program and erase command with the divider at zero; 0 for blank check, which takes 1 tick.
   function automatic int exp_len(input logic [2:0] c);
      return (c == 3'h1) ? 9 : (c == 3'h2) ? 4 : (c == 3'h3) ? 4000 : (c == 3'h4) ? 20000 : 0;
   endfunction
   task automatic launch(input logic [2:0] c, input logic [14:0] ad);
      @(posedge core_clk);
      cmd_launch <= 1'b1;
      cmd_code <= c;
      cmd_addr <= ad;
      @(posedge core_clk);
      cmd_launch <= 1'b0;
      #1;
   endtask
   task automatic pulse(input logic div, input logic [6:0] d);
      @(posedge core_clk);
      div_wr <= div;
      div_wdata <= d;
      err_clear <= ~div;
      done_clear <= ~div;
      @(posedge core_clk);
      {div_wr, err_clear, done_clear} <= 3'b000;
   endtask
   task automatic wait_done;
      n = 1;
      while (cmd_done !== 1'b1 && n < 25000)
      begin
         @(posedge core_clk);
         #1 n++;
      end
      if (n >= 25000)
      begin
         n_mismatch++;
         close_out();
      end
   endtask
   // ==========================================
   // Main sequence.
   initial
   begin
      {arst_n, div_wr, cmd_launch, err_clear, done_clear, secure, fetch_en, fetch_arr} = 8'h00;
      {div_wdata, cmd_code, cmd_addr} = 25'h000_0000;
      prot_boundary = 15'h7FFF;
      array_blank = 2'b11;
      n_mismatch = 0;
      comparisons = 0;
      void'($urandom(7167));
      repeat (4) @(posedge core_clk);
      arst_n <= 1'b1;
      launch(3'h1, 15'h0010);
      chk(access_error_flag === 1'b1 && busy === 1'b0, "launch before load");
      pulse(1'b0, 7'h00);
      pulse(1'b1, 7'h00);
      pulse(1'b1, 7'h3F);
      #1 chk(flash_clock_divider === 8'h80, "divider written twice");
      $display("test divider done");
      for (int c = 0; c < 6; c++)
      begin
         a = 15'($urandom) & 15'h7E00;
         array_blank <= (c == 5) ? 2'b01 : 2'b11;
         launch((c == 5) ? 3'h0 : 3'(c), a);
         chk(busy === 1'b1, "accepted launch not busy");
         chk(pump_on === (c > 0 && c < 5), "charge pump state");
         en = (c == 4) ? 2'b11 : (a[14] ? 2'b10 : 2'b01);
         if (c == 1 || c == 2) chk(prog_en === en, "program array select");
         if (c == 3 || c == 4) chk(erase_en === en, "erase array select");
         if (c == 3) chk(op_addr[14:9] === a[14:9], "page erase page");
         if (c == 3)
         begin
            fetch_en <= 1'b1;
            fetch_arr <= ~a[14];
            repeat (3) @(posedge core_clk);
            #1 chk(rd_valid === 1'b1 && rd_invalid === 1'b0, "idle array stalled");
            fetch_arr <= a[14];
            repeat (3) @(posedge core_clk);
            #1 chk(rd_invalid === 1'b1, "busy array read valid");
            fetch_en <= 1'b0;
            launch(3'h1, a ^ 15'h4000);
            chk(access_error_flag === 1'b1 && prog_en === 2'b00, "overlap launch");
            pulse(1'b0, 7'h00);
         end
         wait_done();
         len = exp_len(3'(c));
         if (c < 5) chk(n + ((c == 3) ? 10 : 0) >= len && n <= len + 4, "command length");
         chk(pump_on === 1'b0 && prog_en === 2'b00 && erase_en === 2'b00, "enables after done");
         if (c == 0 || c == 5) chk(blank_fail === (c == 5), "blank result");
         pulse(1'b0, 7'h00);
         $display("test command %0d done", c);
      end
      prot_boundary <= 15'h4000;
      launch(3'h1, 15'h4100);
      chk(protect_error_flag === 1'b1 && busy === 1'b0, "protected program");
      pulse(1'b0, 7'h00);
      prot_boundary <= 15'h7FFF;
      secure <= 1'b1;
      launch(3'h3, 15'h0200);
      chk(protect_error_flag === 1'b1 && busy === 1'b0, "secure page erase");
      pulse(1'b0, 7'h00);
      $display("test protection done");
      repeat (20) @(posedge core_clk);
      #1 chk(array_pwr === 2'b00, "idle arrays powered");
      fetch_en <= 1'b1;
      @(posedge core_clk);
      fetch_en <= 1'b0;
      @(posedge core_clk);
      #1 chk(rd_valid === 1'b1, "read after power down");
      chk(array_pwr === 2'b11, "power not restored");
      repeat (16) @(posedge core_clk);
      #1 chk(array_pwr === 2'b11, "early power down");
      repeat (2) @(posedge core_clk);
      #1 chk(array_pwr === 2'b00, "late power down");
      $display("test power down done");
      @(posedge core_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      secure <= 1'b0;
      #1 chk(divider_loaded_flag === 1'b0 && flash_clock_divider === 8'h00 && busy === 1'b0, "reset state");
      pulse(1'b1, 7'h41);
      #1 chk(flash_clock_divider === 8'hC1, "second divider load");
      launch(3'h2, 15'h0000);
      wait_done();
      len = exp_len(3'h2) * 8 * 2;
      chk(n >= len && n <= len + 4, "prescaled burst length");
      $display("test prescale done");
      close_out();
   end
endmodule
`default_nettype wire
